/* File: common/fspc_consts.svh */
// constants of the flash self-programming controller
`ifndef FSPC_CONSTS_SVH
`define FSPC_CONSTS_SVH

// control register bit positions
`define FSPC_BIT_EN        0
`define FSPC_BIT_ERASE     1
`define FSPC_BIT_WRITE     2
`define FSPC_BIT_LOCK      3
`define FSPC_BIT_RWWRE     4
`define FSPC_BIT_SIG       5
`define FSPC_BIT_BUSY      6
`define FSPC_BIT_IE        7
// low five-bit command codes
`define FSPC_CMD_LOAD      5'h01
`define FSPC_CMD_ERASE     5'h03
`define FSPC_CMD_WRITE     5'h05
`define FSPC_CMD_LOCK      5'h09
`define FSPC_CMD_RWWRE     5'h11
`define FSPC_CMD_SIG       5'h21
// timed windows in cycles
`define FSPC_STORE_WIN     3'h4
`define FSPC_LOAD_WIN      3'h3
// pointer addresses for lock, fuse and signature reads
`define FSPC_Z_FUSE_LOW    16'h0000
`define FSPC_Z_LOCK        16'h0001
`define FSPC_Z_FUSE_EXT    16'h0002
`define FSPC_Z_FUSE_HIGH   16'h0003
`define FSPC_Z_SIG0        16'h0000
`define FSPC_Z_CAL         16'h0001
`define FSPC_Z_SIG1        16'h0002
`define FSPC_Z_SIG2        16'h0004
// programming time in microseconds and clock rate
`define FSPC_PROG_TIME_US  3700
`define FSPC_CLOCK_MHZ     50
// lock mask of boot lock bits within data byte
`define FSPC_BOOT_LOCK_LSB 2
`define FSPC_BOOT_LOCK_MSB 5

`endif

/* File: common/fspc_pkg.sv */
// types of the flash self-programming controller
package fspc_pkg;
    typedef enum logic [2:0] {
        FSPC_OP_NONE,
        FSPC_OP_LOAD,
        FSPC_OP_ERASE,
        FSPC_OP_WRITE,
        FSPC_OP_LOCK,
        FSPC_OP_RWWRE
    } fspc_op_t;

    typedef struct packed {
        fspc_op_t    op;
        logic [15:0] page;
    } fspc_prog_req_t;

    typedef struct packed {
        logic [7:0] fuseLow;
        logic [7:0] fuseHigh;
        logic [2:0] fuseExt;
        logic [1:0] generalLock;
        logic [7:0] sig0;
        logic [7:0] sig1;
        logic [7:0] sig2;
        logic [7:0] calib;
    } fspc_nv_bits_t;
endpackage : fspc_pkg

/* File: rtl/fspc_controller.sv */
// flash self-programming controller: command decode, timing and status
//
// Behaviour
// - buffer words load one at a time, any order, any phase
// - command X0000011 then store within four cycles erases pointer page
// - erase in read-while-write section leaves other readable; else halts cpu
// - command 00000001 then store loads data word at pointer word address
// - buffer clears after page write, read-enable command and reset
// - eeprom write during partial load discards loaded words
// - command X0000101 then store programs buffer into selected page
// - page write halts cpu only for no-read-while-write section
// - ready interrupt asserted while enabled and store-enable is clear
// - reads of read-while-write section blocked, busy flag set meanwhile
// - lock command programs boot lock bits whose data bits are zero
// - lock programming keeps all flash readable, no halt
// - eeprom write blocks programming commands and fuse or lock reads
// - lock read at pointer 0x0001 within three cycles returns lock bits
// - lock-set and store-enable clear after read or window expiry
// - fuse reads: low at 0x0000, high at 0x0003, extended at 0x0002
// - programmed bits read as zero, unprogrammed as one
// - signature read returns identity or calibration byte by pointer
// - store-enable stays set until erase or write completes
// - undefined low five-bit patterns have no effect
`timescale 1ns/1ps
`default_nettype none
`include "fspc_consts.svh"
module fspc_controller
    import fspc_pkg::*;
#(
    parameter int          WORD_BITS    = 7,
    parameter int          PAGE_BITS    = 8,
    parameter int          NO_READ_WHILE_WRITE_SECTION_PAGE    = 224,
    parameter int unsigned PROG_CYCLES  = `FSPC_PROG_TIME_US * `FSPC_CLOCK_MHZ,
    // arbitrary neutral identity, calibration, fuse and lock values
    parameter logic [7:0]  SIG_BYTE0    = 8'h5A,
    parameter logic [7:0]  SIG_BYTE1    = 8'hA5,
    parameter logic [7:0]  SIG_BYTE2    = 8'h3C,
    parameter logic [7:0]  CAL_BYTE     = 8'h80,
    parameter logic [7:0]  FUSE_LOW     = 8'hFF,
    parameter logic [7:0]  FUSE_HIGH    = 8'hFF,
    parameter logic [2:0]  FUSE_EXT     = 3'h7,
    parameter logic [1:0]  GEN_LOCK     = 2'h3
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // register port
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [7:0]  regWdata,
    output logic      [7:0]  regRdata,
    // cpu instruction events
    input  wire logic        storeInstr,
    input  wire logic        loadInstr,
    input  wire logic [15:0] pointer,
    input  wire logic [15:0] storeData,
    output logic      [7:0]  loadData,
    output logic             loadOverride,
    // eeprom status
    input  wire logic        eepromWriteBusy,
    input  wire logic        eepromWriteStart,
    // flash array side
    output logic             flashErase,
    output logic             flashWrite,
    output logic      [15:0] flashPage,
    output logic      [WORD_BITS-1:0] flashWordAddr,
    input  wire logic [WORD_BITS-1:0] flashWordSel,
    output logic      [15:0] flashWordData,
    // status outputs
    output logic             cpuHalt,
    output logic             rwwBlocked,
    output logic             readyIrq,
    output logic      [3:0]  bootLock
);
    // -----------------------------------------------------------------
    // control register state
    // -----------------------------------------------------------------
    logic       storeEnable;
    logic       irqEnable;
    logic       sectionBusy;
    logic [5:1] cmdBits;
    logic [2:0] storeWin;
    logic [2:0] loadWin;
    logic       opActive;
    logic       opNrww;
    logic [31:0] progCount;
    logic [4:0] lowCmd;
    logic       cmdLegal;
    logic       sigCmd;
    logic       storeHit;
    logic       loadHit;
    logic       opDone;
    logic [7:0] next_loadData;
    fspc_prog_req_t req;
    fspc_nv_bits_t  nv;

    assign nv = '{fuseLow: FUSE_LOW, fuseHigh: FUSE_HIGH, fuseExt: FUSE_EXT,
                  generalLock: GEN_LOCK, sig0: SIG_BYTE0, sig1: SIG_BYTE1,
                  sig2: SIG_BYTE2, calib: CAL_BYTE};

    assign lowCmd   = regWdata[4:0];
    // defined patterns plus the signature read, which uses bit 5
    assign sigCmd   = regWdata[5:0] == {1'b1, `FSPC_CMD_LOAD};
    assign cmdLegal = (lowCmd == `FSPC_CMD_LOAD) || (lowCmd == `FSPC_CMD_ERASE)
                   || (lowCmd == `FSPC_CMD_WRITE) || (lowCmd == `FSPC_CMD_LOCK)
                   || (lowCmd == `FSPC_CMD_RWWRE);

    // -----------------------------------------------------------------
    // store and load windows
    // -----------------------------------------------------------------
    assign storeHit = storeInstr && storeEnable && !opActive && storeWin != 3'h0
                   && !cmdBits[`FSPC_BIT_SIG] && !eepromWriteBusy;
    assign loadHit  = loadInstr && storeEnable && !opActive && loadWin != 3'h0
                   && (cmdBits[`FSPC_BIT_LOCK] || cmdBits[`FSPC_BIT_SIG]);

    always_comb begin
        req.op   = FSPC_OP_NONE;
        req.page = {pointer[15:WORD_BITS+1], {(WORD_BITS+1){1'b0}}};
        if (storeHit) begin
            case ({cmdBits[`FSPC_BIT_RWWRE], cmdBits[`FSPC_BIT_LOCK],
                   cmdBits[`FSPC_BIT_WRITE], cmdBits[`FSPC_BIT_ERASE]})
                4'h0:    req.op = FSPC_OP_LOAD;
                4'h1:    req.op = FSPC_OP_ERASE;
                4'h2:    req.op = FSPC_OP_WRITE;
                4'h4:    req.op = FSPC_OP_LOCK;
                4'h8:    req.op = FSPC_OP_RWWRE;
                default: req.op = FSPC_OP_NONE;
            endcase
        end
    end

    assign opDone = opActive && progCount == 32'h0;

    // -----------------------------------------------------------------
    // control register bits
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            storeEnable <= 1'b0;
            cmdBits     <= '0;
            storeWin    <= 3'h0;
            loadWin     <= 3'h0;
        end else if (regWrite && !storeEnable && !eepromWriteBusy
                     && (cmdLegal || sigCmd)) begin
            storeEnable <= 1'b1;
            cmdBits     <= {sigCmd, regWdata[4:1]};
            storeWin    <= `FSPC_STORE_WIN;
            loadWin     <= `FSPC_LOAD_WIN;
        end else if (opDone) begin
            storeEnable <= 1'b0;
            cmdBits     <= '0;
        end else if (opActive) begin
            storeEnable <= 1'b1;
        end else if (req.op > FSPC_OP_LOAD && req.op < FSPC_OP_RWWRE) begin
            storeWin    <= 3'h0;
            loadWin     <= 3'h0;
        end else if (storeHit || loadHit) begin
            storeEnable <= 1'b0;
            cmdBits     <= '0;
            storeWin    <= 3'h0;
            loadWin     <= 3'h0;
        end else if (storeEnable) begin
            storeWin <= storeWin - 3'h1;
            loadWin  <= (loadWin != 3'h0) ? loadWin - 3'h1 : 3'h0;
            // signature reads also expire with the load window; lock reads only with the store window
            if (storeWin == 3'h1 || ((cmdBits[`FSPC_BIT_LOCK] || cmdBits[`FSPC_BIT_SIG])
                                     && loadWin == 3'h1 && cmdBits[`FSPC_BIT_SIG])) begin
                storeEnable <= 1'b0;
                cmdBits     <= '0;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irqEnable <= 1'b0;
        end else if (regWrite) begin
            irqEnable <= regWdata[`FSPC_BIT_IE];
        end
    end

    // -----------------------------------------------------------------
    // programming timer and section busy
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            opActive  <= 1'b0;
            opNrww    <= 1'b0;
            progCount <= 32'h0;
            flashPage <= 16'h0000;
        end else if (req.op == FSPC_OP_ERASE || req.op == FSPC_OP_WRITE
                     || req.op == FSPC_OP_LOCK) begin
            opActive  <= 1'b1;
            opNrww    <= req.op != FSPC_OP_LOCK
                         && pointer[15:WORD_BITS+1] >= PAGE_BITS'(NO_READ_WHILE_WRITE_SECTION_PAGE);
            progCount <= PROG_CYCLES - 1;
            flashPage <= req.page;
        end else if (opDone) begin
            opActive <= 1'b0;
            opNrww   <= 1'b0;
        end else if (opActive) begin
            progCount <= progCount - 32'h1;
        end
    end

    logic lockOp;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lockOp <= 1'b0;
        end else if (storeHit) begin
            lockOp <= req.op == FSPC_OP_LOCK;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sectionBusy <= 1'b0;
        end else if ((req.op == FSPC_OP_ERASE || req.op == FSPC_OP_WRITE)
                     && pointer[15:WORD_BITS+1] < PAGE_BITS'(NO_READ_WHILE_WRITE_SECTION_PAGE)) begin
            sectionBusy <= 1'b1;
        end else if (req.op == FSPC_OP_RWWRE || req.op == FSPC_OP_LOAD) begin
            sectionBusy <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // boot lock bits, stored programmed-low
    // -----------------------------------------------------------------
    logic [3:0] pendLock;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pendLock <= 4'hF;
        end else if (req.op == FSPC_OP_LOCK) begin
            pendLock <= storeData[`FSPC_BOOT_LOCK_MSB:`FSPC_BOOT_LOCK_LSB];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bootLock <= 4'hF;
        end else if (opDone && lockOp) begin
            bootLock <= bootLock & pendLock;
        end
    end

    // -----------------------------------------------------------------
    // page buffer
    // -----------------------------------------------------------------
    logic bufClear;
    logic loadPending;
    assign bufClear = req.op == FSPC_OP_RWWRE || (opDone && !lockOp && flashWrite)
                   || (eepromWriteStart && loadPending);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            loadPending <= 1'b0;
        end else if (bufClear) begin
            loadPending <= 1'b0;
        end else if (req.op == FSPC_OP_LOAD) begin
            loadPending <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flashErase <= 1'b0;
            flashWrite <= 1'b0;
        end else if (opDone) begin
            flashErase <= 1'b0;
            flashWrite <= 1'b0;
        end else if (req.op == FSPC_OP_ERASE || req.op == FSPC_OP_WRITE) begin
            flashErase <= req.op == FSPC_OP_ERASE;
            flashWrite <= req.op == FSPC_OP_WRITE;
        end
    end

    fspc_page_buffer #(
        .WORD_BITS (WORD_BITS)
    ) u_buffer (
        .clock     (clock),
        .reset_n   (reset_n),
        .clear     (bufClear),
        .writeEn   (req.op == FSPC_OP_LOAD),
        .writeAddr (pointer[WORD_BITS:1]),
        .writeData (storeData),
        .readAddr  (flashWordSel),
        .readData  (flashWordData),
        .readValid ()
    );

    assign flashWordAddr = flashWordSel;

    // -----------------------------------------------------------------
    // lock, fuse and signature reads
    // -----------------------------------------------------------------
    always_comb begin
        next_loadData = 8'hFF;
        if (cmdBits[`FSPC_BIT_SIG]) begin
            case (pointer)
                `FSPC_Z_SIG0: next_loadData = nv.sig0;
                `FSPC_Z_CAL:  next_loadData = nv.calib;
                `FSPC_Z_SIG1: next_loadData = nv.sig1;
                `FSPC_Z_SIG2: next_loadData = nv.sig2;
                default:      next_loadData = 8'hFF;
            endcase
        end else begin
            case (pointer)
                `FSPC_Z_FUSE_LOW:  next_loadData = nv.fuseLow;
                `FSPC_Z_LOCK:      next_loadData = {2'h3, bootLock, nv.generalLock};
                `FSPC_Z_FUSE_EXT:  next_loadData = {5'h1F, nv.fuseExt};
                `FSPC_Z_FUSE_HIGH: next_loadData = nv.fuseHigh;
                default:           next_loadData = 8'hFF;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            loadData     <= 8'hFF;
            loadOverride <= 1'b0;
        end else begin
            loadOverride <= loadHit && (cmdBits[`FSPC_BIT_SIG] || !eepromWriteBusy);
            if (loadHit) begin
                loadData <= next_loadData;
            end
        end
    end

    // -----------------------------------------------------------------
    // status and register read
    // -----------------------------------------------------------------
    assign cpuHalt    = opActive && opNrww;
    assign rwwBlocked = sectionBusy;
    assign readyIrq   = irqEnable && !storeEnable;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= {irqEnable, sectionBusy, cmdBits[`FSPC_BIT_SIG],
                         cmdBits[`FSPC_BIT_RWWRE], cmdBits[`FSPC_BIT_LOCK],
                         cmdBits[`FSPC_BIT_WRITE], cmdBits[`FSPC_BIT_ERASE], storeEnable};
        end
    end
endmodule : fspc_controller
`default_nettype wire

/* File: rtl/fspc_page_buffer.sv */
// temporary page buffer with per-word valid bits and registered read
`timescale 1ns/1ps
`default_nettype none
module fspc_page_buffer #(
    parameter int WORD_BITS = 7
) (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 reset_n,
    // control
    input  wire logic                 clear,
    input  wire logic                 writeEn,
    input  wire logic [WORD_BITS-1:0] writeAddr,
    input  wire logic [15:0]          writeData,
    input  wire logic [WORD_BITS-1:0] readAddr,
    // read side
    output logic      [15:0]          readData,
    output logic                      readValid
);
    localparam int DEPTH = 1 << WORD_BITS;

    logic [15:0]      mem [DEPTH];
    logic [DEPTH-1:0] loaded;

    always_ff @(posedge clock) begin
        if (writeEn) begin
            mem[writeAddr] <= writeData;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            loaded <= '0;
        end else if (clear) begin
            loaded <= '0;
        end else if (writeEn) begin
            loaded[writeAddr] <= 1'b1;
        end
    end

    // erased cells read as all ones
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            readData  <= 16'hFFFF;
            readValid <= 1'b0;
        end else begin
            readData  <= loaded[readAddr] ? mem[readAddr] : 16'hFFFF;
            readValid <= loaded[readAddr];
        end
    end
endmodule : fspc_page_buffer
`default_nettype wire

/* File: sim/flash_self_programming_control_tb.sv */
// self-checking bench of the flash self-programming controller
`timescale 1ns/1ps
`default_nettype none
module flash_self_programming_control_tb;
    logic        clock = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic        storeInstr = 1'b0, loadInstr = 1'b0, eepromWriteBusy = 1'b0;
    logic        eepromWriteStart = 1'b0, loadOverride, flashErase, flashWrite;
    logic        cpuHalt, rwwBlocked, readyIrq;
    logic [7:0]  regWdata = 8'h00, regRdata, loadData, rv;
    logic [15:0] pointer = 16'h0000, storeData = 16'h0000, flashPage, flashWordData;
    logic [6:0]  flashWordSel;
    logic [3:0]  bootLock;
    int          fail_count = 0, samples_checked = 0, cycles = 0;
    logic [7:0]  rdCode [8] = '{8'h89, 8'h89, 8'h89, 8'h89, 8'hA1, 8'hA1, 8'hA1, 8'hA1};
    logic [15:0] rdPtr [8]  = '{16'h1, 16'h0, 16'h3, 16'h2, 16'h0, 16'h2, 16'h4, 16'h1};
    logic [7:0]  rdExp [8]  = '{8'h32, 8'hE2, 8'h99, 8'h05, 8'h5A, 8'hA5, 8'h3C, 8'h80};
    logic [7:0]  rdMask [8] = '{8'h3F, 8'hFF, 8'hFF, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0]  badCode [6] = '{8'h07, 8'h0F, 8'h13, 8'h19, 8'h1F, 8'h0D};

    always #10 clock = ~clock;

    fspc_controller #(.PROG_CYCLES(200), .FUSE_LOW(8'hE2), .FUSE_HIGH(8'h99),
        .FUSE_EXT(3'h5), .GEN_LOCK(2'h2)) fspc_controller_inst (
        .clock(clock), .reset_n(reset_n), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata), .regRdata(regRdata), .storeInstr(storeInstr),
        .loadInstr(loadInstr), .pointer(pointer), .storeData(storeData),
        .loadData(loadData), .loadOverride(loadOverride), .eepromWriteBusy(eepromWriteBusy),
        .eepromWriteStart(eepromWriteStart), .flashErase(flashErase),
        .flashWrite(flashWrite), .flashPage(flashPage), .flashWordAddr(),
        .flashWordSel(flashWordSel), .flashWordData(flashWordData), .cpuHalt(cpuHalt),
        .rwwBlocked(rwwBlocked), .readyIrq(readyIrq), .bootLock(bootLock));

    fspc_flash_model fspc_flash_model_inst (.clock(clock),
        .flashErase(flashErase), .flashWrite(flashWrite),
        .flashWordData(flashWordData), .flashWordSel(flashWordSel));

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    task automatic wr(input logic [7:0] d);
        regWdata <= d;
        regWrite <= 1'b1;
        tick(1);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd();
        regRead <= 1'b1;
        tick(1);
        regRead <= 1'b0;
        #1 rv = regRdata;
        tick(1);
    endtask : rd

    task automatic cmd(input logic [7:0] c, input int dly, input logic [15:0] p, d);
        pointer   <= p;
        storeData <= d;
        wr(c);
        tick(dly - 1);
        storeInstr <= 1'b1;
        tick(1);
        storeInstr <= 1'b0;
    endtask : cmd

    task automatic wait_idle();
        rd();
        for (int i = 0; i < 300 && rv[0] !== 1'b0; i++) rd();
    endtask : wait_idle

    task automatic op(input logic [7:0] c, input logic [15:0] p);
        cmd(c, 1, p, 16'h0000);
        #1 chk(16'(flashErase | flashWrite), 16'h1);
        chk(16'(cpuHalt), 16'(p[15:8] >= 8'hE0));
        chk(16'(rwwBlocked), 16'(p[15:8] < 8'hE0));
        chk(16'(readyIrq), 16'h0);
        chk(flashPage, {p[15:8], 8'h00});
        tick(1);
        wait_idle();
        chk(16'(rv), (p[15:8] < 8'hE0) ? 16'h00C0 : 16'h0080);
        chk(16'(readyIrq), 16'h1);
    endtask : op

    task automatic ld(input logic [7:0] c, input logic [15:0] p, input logic ov);
        pointer <= p;
        wr(c);
        loadInstr <= 1'b1;
        tick(1);
        loadInstr <= 1'b0;
        #1 rv = loadData;
        chk(16'(loadOverride), 16'(ov));
        tick(1);
    endtask : ld

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        tick(16);
        reset_n <= 1'b1;
        tick(1);
        rd();
        chk(16'(rv), 16'h0000);
        chk(16'(bootLock), 16'h000F);
        cmd(8'h01, 1, 16'h030B, 16'hA5C3);
        op(8'h83, 16'h0377);
        cmd(8'h01, 4, 16'h0314, 16'h1234);
        op(8'h85, 16'h0300);
        chk(fspc_flash_model_inst.cells[5], 16'hA5C3);
        chk(fspc_flash_model_inst.cells[10], 16'h1234);
        chk(fspc_flash_model_inst.cells[0], 16'hFFFF);
        cmd(8'h91, 1, 16'h0000, 16'h0000);
        rd();
        chk(16'(rv), 16'h0080);
        cmd(8'h83, 5, 16'h0300, 16'h0000);
        #1 chk(16'(flashErase), 16'h0);
        tick(1);
        eepromWriteBusy <= 1'b1;
        cmd(8'h83, 1, 16'h0300, 16'h0000);
        #1 chk(16'(flashErase), 16'h0);
        tick(1);
        ld(8'h89, 16'h0000, 1'b0);
        eepromWriteBusy <= 1'b0;
        foreach (badCode[i]) begin
            wr(badCode[i]);
            rd();
            chk(16'(rv), 16'h0000);
        end
        for (int k = 0; k < 3; k++) begin
            cmd(8'h01, 1, 16'h030A, 16'h0F0F);
            if (k == 0) cmd(8'h91, 1, 16'h0000, 16'h0000);
            if (k == 1) eepromWriteStart <= 1'b1;
            if (k == 2) reset_n <= 1'b0;
            tick(2);
            eepromWriteStart <= 1'b0;
            reset_n <= 1'b1;
            tick(1);
            op(8'h83, 16'h0300);
            op(8'h85, 16'h0300);
            cmd(8'h91, 1, 16'h0000, 16'h0000);
            chk(fspc_flash_model_inst.cells[5], 16'hFFFF);
        end
        op(8'h83, 16'hE100);
        cmd(8'h89, 1, 16'h0001, 16'h00F3);
        tick(1);
        wait_idle();
        chk(16'(rv), 16'h0080);
        chk(16'(bootLock), 16'h000C);
        foreach (rdCode[i]) begin
            ld(rdCode[i], rdPtr[i], 1'b1);
            chk(16'(rv & rdMask[i]), 16'(rdExp[i]));
            rd();
            chk(16'(rv), 16'h0080);
        end
        test_done();
    end
endmodule : flash_self_programming_control_tb
`default_nettype wire

/* File: sim/fspc_controller_sva.sv */
// checker of the flash self-programming controller ports
`timescale 1ns/1ps
`default_nettype none
module fspc_controller_sva #(
    parameter int          WORD_BITS   = 7,
    parameter int          NO_READ_WHILE_WRITE_SECTION_PAGE   = 224,
    parameter int unsigned PROG_CYCLES = 20
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // cpu side
    input  wire logic        storeInstr,
    input  wire logic        loadInstr,
    input  wire logic        loadOverride,
    input  wire logic        eepromWriteBusy,
    // flash and status
    input  wire logic        flashErase,
    input  wire logic        flashWrite,
    input  wire logic [15:0] flashPage,
    input  wire logic        cpuHalt,
    input  wire logic        rwwBlocked,
    input  wire logic        readyIrq,
    input  wire logic [3:0]  bootLock
);
    logic        opBusy;
    logic        rwwPage;
    int unsigned opCount;

    assign opBusy  = flashErase | flashWrite;
    assign rwwPage = (32'(flashPage) >> (WORD_BITS + 1)) < NO_READ_WHILE_WRITE_SECTION_PAGE;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            opCount <= 0;
        end else begin
            opCount <= opBusy ? opCount + 1 : 0;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_op_exclusive: assert property (!(flashErase && flashWrite))
        else $error("erase and write at once");
    a_op_after_store: assert property ($rose(opBusy) |-> $past(storeInstr))
        else $error("operation without store");
    a_eeprom_blocks: assert property ($rose(opBusy) |-> !$past(eepromWriteBusy))
        else $error("operation started during eeprom write");
    a_halt_by_page: assert property (opBusy |-> (cpuHalt == !rwwPage))
        else $error("halt does not match section");
    a_halt_only_op: assert property (cpuHalt |-> opBusy)
        else $error("halt outside erase or write");
    a_busy_rww_op: assert property ((opBusy && rwwPage) |-> rwwBlocked)
        else $error("busy flag low during section operation");
    a_irq_quiet_op: assert property (opBusy |-> !readyIrq)
        else $error("ready interrupt during operation");
    a_op_bound: assert property (opCount <= PROG_CYCLES + 2)
        else $error("operation too long");
    a_op_length: assert property ($fell(opBusy) |-> ($past(opCount) + 2 >= PROG_CYCLES))
        else $error("operation too short");
    a_page_latched: assert property ((opBusy && $past(opBusy)) |-> $stable(flashPage))
        else $error("page changed during operation");
    a_load_answer: assert property (loadOverride |-> $past(loadInstr))
        else $error("load result without load");
    a_lock_sticky: assert property ((bootLock & ~$past(bootLock)) == 4'h0)
        else $error("programmed lock bit returned to one");

    c_erase: cover property ($rose(flashErase));
    c_write: cover property ($rose(flashWrite));
    c_halt: cover property ($rose(cpuHalt));
    c_load: cover property (loadOverride);
endmodule : fspc_controller_sva

bind fspc_controller fspc_controller_sva #(
    .WORD_BITS   (WORD_BITS),
    .NO_READ_WHILE_WRITE_SECTION_PAGE   (NO_READ_WHILE_WRITE_SECTION_PAGE),
    .PROG_CYCLES (PROG_CYCLES)
) fspc_controller_sva_inst (
    .clock(clock), .reset_n(reset_n), .storeInstr(storeInstr), .loadInstr(loadInstr),
    .loadOverride(loadOverride), .eepromWriteBusy(eepromWriteBusy),
    .flashErase(flashErase), .flashWrite(flashWrite), .flashPage(flashPage),
    .cpuHalt(cpuHalt), .rwwBlocked(rwwBlocked), .readyIrq(readyIrq), .bootLock(bootLock)
);
`default_nettype wire

/* File: sim/fspc_flash_model.sv */
// flash array model: scans word select and programs cells
`timescale 1ns/1ps
`default_nettype none
module fspc_flash_model #(
    parameter int WORD_BITS = 7
) (
    // clock
    input  wire logic                 clock,
    // array controls
    input  wire logic                 flashErase,
    input  wire logic                 flashWrite,
    input  wire logic [15:0]          flashWordData,
    output logic      [WORD_BITS-1:0] flashWordSel
);
    logic [WORD_BITS-1:0] prevSel;
    logic [15:0]          cells [2**WORD_BITS];

    // cells are nonvolatile, so no reset
    initial begin
        flashWordSel = '0;
        prevSel = '0;
        foreach (cells[i]) cells[i] = 16'hFFFF;
    end

    // select runs free, buffer word arrives a cycle later
    always @(posedge clock) begin
        flashWordSel <= flashWordSel + 1'b1;
        prevSel      <= flashWordSel;
        if (flashErase) begin
            foreach (cells[i]) cells[i] <= 16'hFFFF;
        end else if (flashWrite) begin
            cells[prevSel] <= cells[prevSel] & flashWordData;
        end
    end
endmodule : fspc_flash_model
`default_nettype wire
